// File: rcc_reset_ctrl.v
// reset control: merges eight reset sources, times the warm-up release,
// and holds the protected configuration and reset-cause registers on apb.
// assumes ref_clk_in is the high-frequency oscillator clock, internal reset
// sources are synchronous one-cycle or longer levels, rst_b_in is power-on.
//
// What this block does
// R1: eight sources (pin, power-on, vd1, vd2, watchdog, clock, trim, flash) merge into one reset
// R2: config bit 0 committed 0 accepts the reset pin, 1 ignores it
// R3: written disable bit takes effect only after key 0xb2 copies it in
// R4: committed disable cleared by power-on only; written copy by every reset
// R5: config bits 7..3 read zero; bits 2..0 read/write, reset to zero
// R6: key 0xb2 commits bit 0, 0xd4 bits 1-2, 0x71 flag clear, others ignored
// R7: software treats the key register as write-only, no read-modify-write
// R8: software writes key codes only in normal high-speed mode, gear select 00
// R9: status register bits 2..0 show the committed configuration bits
// R10: cause flags latch on flash, trim, vd2, vd1, clock and watchdog resets
// R11: cause bit 5 shows abnormal trimming data, apart from the trim flag
// R12: cause flags cleared only by power-on, pin reset or flag clear procedure
// R13: clear request plus key 0x71 zeroes all flags and drops the request
// R14: cause bit 7 is the write-only clear request, reads as zero
// R15: all sources feed warm-up; during reset counter, cpu, peripherals held
// R16: after release the warm-up counter counts; cpu held until it completes
// R17: trimming data loads into the detector ladder during warm-up
// R18: after warm-up the cpu starts at the vector held at 0xfffe/0xffff
// R19: a reset during warm-up resets the counter so warm-up restarts
// R20: every source gives the same sequence except some registers and detectors
// R21: voltage detectors disabled only by pin reset or power-on reset
// R22: power-on and pin reset are ored, either one alone resets
// R23: key and status share one address: writes to key, reads give status
//
// Local design decision: the APB interface to the registers.
`include "rcc_defines.vh"

module rcc_reset_ctrl
(
  // clock, reset, enable
  input  wire        ref_clk_in,
  input  wire        rst_b_in,
  input  wire        clk_en_in,
  // reset sources
  input  wire        ext_reset_b_in,
  input  wire        por_in,
  input  wire        volt_detect1_in,
  input  wire        volt_detect2_in,
  input  wire        watchdog_in,
  input  wire        sysclk_fault_in,
  input  wire        trim_fault_in,
  input  wire        flash_standby_in,
  input  wire        trim_abnormal_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [15:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // reset outputs
  output wire        sys_reset_b_out,
  output wire        cpu_reset_b_out,
  output wire        warmup_active_out,
  output wire        trim_load_out,
  output wire        volt_detect_disable_out,
  output wire        cpu_start_out,
  output wire [15:0] reset_vector_addr_out,
  output wire [2:0]  config_committed_out
);

  // ========================================================================
  // state encoding
  localparam [1:0] ST_RESET  = 2'h0;
  localparam [1:0] ST_WARMUP = 2'h1;
  localparam [1:0] ST_RUN    = 2'h2;

  // ========================================================================
  // declarations
  reg         ext_s1_r;
  reg         ext_s2_r;
  reg         ext_s3_r;
  reg         ext_lvl_b_r;
  reg  [2:0]  cfg_wr_r;
  reg  [2:0]  cfg_com_r;
  reg  [6:0]  cause_r;
  reg         fclr_req_r;
  reg  [1:0]  state_r;
  reg  [15:0] wu_cnt_r;
  reg         sys_reset_b_r;
  reg         cpu_reset_b_r;
  reg         warmup_r;
  reg         trim_load_r;
  reg         vd_dis_r;
  reg         cpu_start_r;
  reg  [15:0] vector_r;
  reg  [31:0] prdata_r;
  reg         pready_r;
  reg         pslverr_r;
  reg  [31:0] rd_nxt;
  reg         err_nxt;
  reg  [1:0]  state_nxt;
  reg  [6:0]  cause_nxt;

  wire        ext_active;
  wire        pin_or_por;
  wire        internal_rst;
  wire        any_rst;
  wire        acc;
  wire        wr_en;
  wire        hit_cause;
  wire        hit_cfg;
  wire        hit_key;
  wire [7:0]  wbyte;
  wire        key_flag_clr;
  wire [6:0]  cause_set;

  // ========================================================================
  // reset pin synchroniser: a change counts once stages two and three agree
  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ext_s1_r    <= 1'b1;
      ext_s2_r    <= 1'b1;
      ext_s3_r    <= 1'b1;
      ext_lvl_b_r <= 1'b1;
    end
    else if (clk_en_in)
    begin
      ext_s1_r <= ext_reset_b_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r)
      begin
        ext_lvl_b_r <= ext_s3_r;
      end
    end
  end

  // ========================================================================
  // reset merging
  assign ext_active   = !ext_lvl_b_r && !cfg_com_r[`RCC_CFG_EXT_DIS];     // R2
  assign pin_or_por   = ext_active || por_in;                              // R22
  assign internal_rst = volt_detect1_in || volt_detect2_in || watchdog_in ||
                        sysclk_fault_in || trim_fault_in || flash_standby_in;
  assign any_rst      = pin_or_por || internal_rst;                        // R1 R20

  // ========================================================================
  // apb decode
  assign acc       = psel_in && penable_in && pready_r;
  assign wr_en     = acc && pwrite_in && !err_nxt;
  assign wbyte     = pwdata_in[7:0];
  assign hit_cause = (paddr_in == `RCC_ADDR_CAUSE);
  assign hit_cfg   = (paddr_in == `RCC_ADDR_CONFIG);
  assign hit_key   = (paddr_in == `RCC_ADDR_KEY);                          // R23
  assign key_flag_clr = wr_en && hit_key && (wbyte == `RCC_KEY_FLAG_CLR) &&
                        fclr_req_r;                                        // R13

  always @*
  begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (hit_cause)
    begin
      rd_nxt = {25'h0000000, cause_r};                                    // R14
    end
    else if (hit_cfg)
    begin
      rd_nxt = {29'h00000000, cfg_wr_r};                                   // R5
    end
    else if (hit_key)
    begin
      rd_nxt = {29'h00000000, cfg_com_r};                                  // R9 R23
    end
    else
    begin
      err_nxt = 1'b1;
    end
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else if (clk_en_in)
    begin
      pready_r  <= psel_in && penable_in && !pready_r;
      pslverr_r <= psel_in && penable_in && !pready_r && err_nxt;
      if (psel_in && penable_in && !pready_r && !pwrite_in)
      begin
        prdata_r <= rd_nxt;
      end
      else
      begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // ========================================================================
  // configuration: written copy and committed copy
  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cfg_wr_r  <= `RCC_CFG_RESET;
      cfg_com_r <= `RCC_CFG_RESET;
    end
    else if (clk_en_in)
    begin
      if (any_rst)
      begin
        cfg_wr_r <= `RCC_CFG_RESET;                                        // R4
      end
      else if (wr_en && hit_cfg)
      begin
        cfg_wr_r <= wbyte[2:0];                                            // R5
      end
      if (por_in)
      begin
        cfg_com_r <= `RCC_CFG_RESET;                                       // R4
      end
      else if (wr_en && hit_key && (wbyte == `RCC_KEY_EXT_DIS))
      begin
        cfg_com_r[`RCC_CFG_EXT_DIS] <= cfg_wr_r[`RCC_CFG_EXT_DIS];        // R3 R6
      end
      else if (wr_en && hit_key && (wbyte == `RCC_KEY_CFG12))
      begin
        cfg_com_r[2:1] <= cfg_wr_r[2:1];                                   // R6
      end
    end
  end

  // ========================================================================
  // reset-cause flags: a new event wins over a clear in the same cycle
  assign cause_set = {flash_standby_in, trim_abnormal_in, trim_fault_in,
                      volt_detect2_in, volt_detect1_in, sysclk_fault_in,
                      watchdog_in};                                        // R10 R11

  always @*
  begin
    cause_nxt = cause_r;
    if (pin_or_por || key_flag_clr)
    begin
      cause_nxt = `RCC_CAUSE_RESET;                                        // R12 R13
    end
    cause_nxt = cause_nxt | cause_set;
  end

  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cause_r    <= `RCC_CAUSE_RESET;
      fclr_req_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cause_r <= cause_nxt;
      if (any_rst || key_flag_clr)
      begin
        fclr_req_r <= 1'b0;                                                // R13
      end
      else if (wr_en && hit_cause)
      begin
        fclr_req_r <= wbyte[`RCC_CAUSE_FCLR];                              // R14
      end
    end
  end

  // ========================================================================
  // reset sequencer: hold, warm-up, run
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET:
        if (!any_rst)
        begin
          state_nxt = ST_WARMUP;                                           // R16
        end
      ST_WARMUP:
        if (any_rst)
        begin
          state_nxt = ST_RESET;                                            // R19
        end
        else if (wu_cnt_r == `RCC_WARMUP_CYCLES - 16'h0001)
        begin
          state_nxt = ST_RUN;
        end
      ST_RUN:
        if (any_rst)
        begin
          state_nxt = ST_RESET;
        end
      default:
        state_nxt = ST_RESET;
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_r       <= ST_RESET;
      wu_cnt_r      <= 16'h0000;
      sys_reset_b_r <= 1'b0;
      cpu_reset_b_r <= 1'b0;
      warmup_r      <= 1'b0;
      trim_load_r   <= 1'b0;
      vd_dis_r      <= 1'b1;
      cpu_start_r   <= 1'b0;
      vector_r      <= `RCC_VECTOR_ADDR;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
      if (state_nxt == ST_WARMUP && state_r == ST_WARMUP)
      begin
        wu_cnt_r <= wu_cnt_r + 16'h0001;                                   // R16
      end
      else
      begin
        wu_cnt_r <= 16'h0000;                                              // R15 R19
      end
      sys_reset_b_r <= (state_nxt != ST_RESET);                            // R15
      cpu_reset_b_r <= (state_nxt == ST_RUN);                              // R16
      warmup_r      <= (state_nxt == ST_WARMUP);
      trim_load_r   <= (state_nxt == ST_WARMUP);                           // R17
      vd_dis_r      <= pin_or_por;                                         // R21
      cpu_start_r   <= (state_nxt == ST_RUN) && (state_r == ST_WARMUP);    // R18
      vector_r      <= `RCC_VECTOR_ADDR;                                   // R18
    end
  end

  // ========================================================================
  // outputs
  assign prdata_out              = prdata_r;
  assign pready_out              = pready_r;
  assign pslverr_out             = pslverr_r;
  assign sys_reset_b_out         = sys_reset_b_r;
  assign cpu_reset_b_out         = cpu_reset_b_r;
  assign warmup_active_out       = warmup_r;
  assign trim_load_out           = trim_load_r;
  assign volt_detect_disable_out = vd_dis_r;
  assign cpu_start_out           = cpu_start_r;
  assign reset_vector_addr_out   = vector_r;
  assign config_committed_out    = cfg_com_r;

endmodule

// File: rcc_defines.vh
// offsets, field positions, key codes, reset values and timing counts of the
// reset control block; assumes plain verilog-2005 inclusion by bare name
`ifndef RCC_DEFINES_VH
`define RCC_DEFINES_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define RCC_IDX_CAUSE       16'h0fcc
`define RCC_IDX_CONFIG      16'h0fde
`define RCC_IDX_KEY         16'h0fdf
`define RCC_ADDR_CAUSE      16'h3f30
`define RCC_ADDR_CONFIG     16'h3f78
`define RCC_ADDR_KEY        16'h3f7c

// ==========================================================================
// key codes
`define RCC_KEY_EXT_DIS     8'hb2
`define RCC_KEY_CFG12       8'hd4
`define RCC_KEY_FLAG_CLR    8'h71

// ==========================================================================
// field positions
`define RCC_CFG_EXT_DIS     0
`define RCC_CFG_BIT1        1
`define RCC_CFG_BIT2        2
`define RCC_CAUSE_WDT       0
`define RCC_CAUSE_SYSCLK    1
`define RCC_CAUSE_VD1       2
`define RCC_CAUSE_VD2       3
`define RCC_CAUSE_TRIM      4
`define RCC_CAUSE_TRIM_BAD  5
`define RCC_CAUSE_FLASH     6
`define RCC_CAUSE_FCLR      7

// ==========================================================================
// reset values
`define RCC_CFG_RESET       3'h0
`define RCC_CAUSE_RESET     7'h00
`define RCC_VECTOR_ADDR     16'hfffe

// ==========================================================================
// timing: warm-up length in high-frequency clock cycles (plain default)
`define RCC_WARMUP_CYCLES   16'h0800

`endif

// File: rcc_reset_ctrl_properties.sv
// checker of the reset control block: readback, reset sequencing, warm-up
// assumes only the ports of rcc_reset_ctrl; bound at the foot of this file
`include "rcc_defines.vh"

module rcc_reset_ctrl_props
(
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic        clk_en_in,
  // sources
  input wire logic        por_in,
  input wire logic        watchdog_in,
  // apb
  input wire logic        psel_in,
  input wire logic        pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  // reset outputs
  input wire logic        sys_reset_b_out,
  input wire logic        cpu_reset_b_out,
  input wire logic        warmup_active_out,
  input wire logic        volt_detect_disable_out,
  input wire logic        cpu_start_out,
  input wire logic [15:0] reset_vector_addr_out,
  input wire logic [2:0]  config_committed_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [15:0] wcnt_r;
  logic        rd_w;

  // ==========================================================================
  // warm-up length counter
  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      wcnt_r <= 16'h0;
    else if (clk_en_in)
      wcnt_r <= warmup_active_out ? wcnt_r + 16'h1 : 16'h0;
  end
  assign rd_w = psel_in && pready_out && !pwrite_in;

  // ==========================================================================
  // assertions
  a_status_mirror: assert property (rd_w && paddr_in == `RCC_ADDR_KEY |->
    prdata_out == {29'h0, config_committed_out}) else $error("status readback wrong");
  a_config_upper: assert property (rd_w && paddr_in == `RCC_ADDR_CONFIG |->
    prdata_out[31:3] == 29'h0) else $error("config upper bits not zero");
  a_clear_bit_zero: assert property (rd_w && paddr_in == `RCC_ADDR_CAUSE |->
    prdata_out[31:7] == 25'h0) else $error("clear request reads one");
  a_source_resets: assert property (clk_en_in && watchdog_in |=>
    !sys_reset_b_out && !cpu_reset_b_out) else $error("source did not reset");
  a_cpu_held: assert property (warmup_active_out |->
    sys_reset_b_out && !cpu_reset_b_out) else $error("cpu free during warm-up");
  a_start_vector: assert property (cpu_start_out && clk_en_in |-> cpu_reset_b_out &&
    reset_vector_addr_out == `RCC_VECTOR_ADDR ##1 !cpu_start_out) else $error("bad start");
  a_warmup_length: assert property ($fell(warmup_active_out) && sys_reset_b_out |->
    wcnt_r == `RCC_WARMUP_CYCLES) else $error("warm-up length wrong");
  a_por_vd_off: assert property (clk_en_in && por_in |=>
    volt_detect_disable_out) else $error("detectors not disabled");
endmodule

bind rcc_reset_ctrl rcc_reset_ctrl_props rcc_reset_ctrl_props_inst (.ref_clk_in, .rst_b_in,
  .clk_en_in, .por_in, .watchdog_in, .psel_in, .pwrite_in, .paddr_in, .prdata_out,
  .pready_out, .sys_reset_b_out, .cpu_reset_b_out, .warmup_active_out,
  .volt_detect_disable_out, .cpu_start_out, .reset_vector_addr_out, .config_committed_out);

// File: test_rcc_reset_ctrl.sv
// testbench of the reset control block: apb register checks and reset sequences
// assumes rcc_reset_ctrl and its bound checker are compiled first
`include "rcc_defines.vh"

module test_rcc_reset_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst_b;
  logic        en;
  logic        ext_b;
  logic [6:0]  src;
  logic        trim_bad;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         perr;
  wire         sys_b;
  wire         cpu_b;
  wire         vd_dis;
  wire         start;
  wire         trim_ld;
  wire  [2:0]  cfg;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] exp_f;
  int          mismatches;
  int          cmp_count;
  int          cycles;
  int          n;

  rcc_reset_ctrl rcc_reset_ctrl_inst (.ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(en),
    .ext_reset_b_in(ext_b), .por_in(src[6]), .volt_detect1_in(src[2]),
    .volt_detect2_in(src[3]), .watchdog_in(src[0]), .sysclk_fault_in(src[1]),
    .trim_fault_in(src[4]), .flash_standby_in(src[5]), .trim_abnormal_in(trim_bad),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .sys_reset_b_out(sys_b),
    .cpu_reset_b_out(cpu_b), .warmup_active_out(), .trim_load_out(trim_ld),
    .volt_detect_disable_out(vd_dis), .cpu_start_out(start), .reset_vector_addr_out(),
    .config_committed_out(cfg));

  // ==========================================================================
  // tasks
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask
  task wait_start;
    n = 0;
    while (start !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk(start, 1);
    chk(trim_ld, 0);
  endtask
  // one-cycle source pulse, then the whole reset and warm-up sequence
  task pulse(input int i, input logic vd);
    @(posedge clk);
    src[i] <= 1'b1;
    @(posedge clk);
    src[i] <= 1'b0;
    @(posedge clk);
    chk(sys_b, 0);
    chk(vd_dis, vd);
    @(posedge clk);
    chk(trim_ld, 1);
    wait_start;
  endtask

  // ==========================================================================
  // clock, timeout and sequence
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      conclude;
    end
  end
  initial
  begin
    {rst_b, ext_b, src, trim_bad, psel, pen, pwr, paddr, pwdata} = '0;
    ext_b = 1'b1;
    en = 1'b1;
    {mismatches, cmp_count, cycles, exp_f} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_start;
    rd(`RCC_ADDR_CAUSE, 0);
    rd(`RCC_ADDR_CONFIG, 0);
    rd(16'h0100, 0);
    chk(rerr, 1);
    xfer(1'b1, `RCC_ADDR_CONFIG, 8'hff);
    rd(`RCC_ADDR_CONFIG, 7);
    rd(`RCC_ADDR_KEY, 0);
    xfer(1'b1, `RCC_ADDR_KEY, 8'h55);
    rd(`RCC_ADDR_KEY, 0);
    xfer(1'b1, `RCC_ADDR_KEY, `RCC_KEY_EXT_DIS);
    rd(`RCC_ADDR_KEY, 1);
    xfer(1'b1, `RCC_ADDR_KEY, `RCC_KEY_CFG12);
    rd(`RCC_ADDR_KEY, 7);
    chk(cfg, 7);
    ext_b <= 1'b0;
    repeat (10) @(posedge clk);
    chk(sys_b, 1);
    ext_b <= 1'b1;
    // enable low freezes the block: a source pulse must not reset it
    en <= 1'b0;
    src[0] <= 1'b1;
    repeat (3) @(posedge clk);
    chk(sys_b, 1);
    src[0] <= 1'b0;
    en <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      pulse(i, 1'b0);
      exp_f[i < 5 ? i : 6] = 1'b1;
      rd(`RCC_ADDR_CAUSE, exp_f);
    end
    rd(`RCC_ADDR_CONFIG, 0);
    rd(`RCC_ADDR_KEY, 7);
    trim_bad <= 1'b1;
    repeat (2) @(posedge clk);
    trim_bad <= 1'b0;
    exp_f[5] = 1'b1;
    rd(`RCC_ADDR_CAUSE, exp_f);
    src[0] <= 1'b1;
    repeat (1000) @(posedge clk);
    src[0] <= 1'b0;
    repeat (1000) @(posedge clk);
    pulse(0, 1'b0);
    src[0] <= 1'b1;
    @(posedge clk);
    src[0] <= 1'b0;
    repeat (1500) @(posedge clk);
    chk(cpu_b, 0);
    wait_start;
    xfer(1'b1, `RCC_ADDR_KEY, `RCC_KEY_FLAG_CLR);
    rd(`RCC_ADDR_CAUSE, exp_f);
    xfer(1'b1, `RCC_ADDR_CAUSE, 8'h80);
    rd(`RCC_ADDR_CAUSE, exp_f);
    xfer(1'b1, `RCC_ADDR_KEY, `RCC_KEY_FLAG_CLR);
    rd(`RCC_ADDR_CAUSE, 0);
    pulse(0, 1'b0);
    pulse(6, 1'b1);
    rd(`RCC_ADDR_KEY, 0);
    rd(`RCC_ADDR_CAUSE, 0);
    pulse(1, 1'b0);
    ext_b <= 1'b0;
    repeat (8) @(posedge clk);
    chk(sys_b, 0);
    chk(vd_dis, 1);
    ext_b <= 1'b1;
    wait_start;
    rd(`RCC_ADDR_CAUSE, 0);
    conclude;
  end
endmodule
